//--- core/cfgt_pkg.sv
// constants and types of the gate timing block
package cfgt_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int WAKE_NS        = 2200;
	localparam int ZC_TIMEOUT_NS  = 2200;
	localparam int LH_FIXED_NS    = 40;
	localparam int ZC_TO_HIGH_NS  = 50;
	localparam int BLANK_GND_NS   = 130;
	localparam int BLANK_REF_NS   = 200;
	localparam int MIN_ON_GND_NS  = 65;
	localparam int MIN_ON_REF_NS  = 90;
	localparam int CSF_REF_NS     = 2000;
	localparam int CSF_GND_NS     = 1000;

	// least times round up, longest times round down
	localparam logic [7:0] WAKE_CYC       = 8'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ZC_TIMEOUT_CYC = 8'(ZC_TIMEOUT_NS / CLK_PERIOD_NS);
	localparam logic [7:0] LH_FIXED_CYC   = 8'((LH_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ZC_TO_HIGH_CYC = 8'((ZC_TO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BLANK_GND_CYC  = 8'((BLANK_GND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BLANK_REF_CYC  = 8'((BLANK_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MIN_ON_GND_CYC = 8'((MIN_ON_GND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MIN_ON_REF_CYC = 8'((MIN_ON_REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] CSF_REF_CYC    = 8'(CSF_REF_NS / CLK_PERIOD_NS);
	localparam logic [7:0] CSF_GND_CYC    = 8'(CSF_GND_NS / CLK_PERIOD_NS);

	// dead time extension: full deficit code adds 40 percent
	localparam logic [4:0] DEFICIT_MAX    = 5'h10;
	localparam logic [7:0] EXT_DIVISOR    = 8'h28;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int          WB_AW          = 8;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_PULSES    = 8'h04;
	localparam logic [7:0]  ADDR_BURST_OFF = 8'h08;
	localparam logic [7:0]  ADDR_LOW_ON    = 8'h0c;
	localparam logic [7:0]  ADDR_HIGH_BASE = 8'h10;
	localparam logic [7:0]  ADDR_TZ_MIN    = 8'h14;
	localparam logic [7:0]  ADDR_DEFICIT   = 8'h18;
	localparam logic [7:0]  ADDR_STATUS    = 8'h1c;

	localparam int CTRL_RUN       = 0;
	localparam int CTRL_BURST     = 1;
	localparam int CTRL_LOW_POWER = 2;
	localparam int CTRL_STANDBY   = 3;

	localparam int ST_RELEASED    = 0;
	localparam int ST_STRAP       = 1;
	localparam int ST_IN_FAULT    = 2;
	localparam int ST_CS_FAULT    = 3;
	localparam int ST_BIAS_FAULT  = 4;
	localparam int ST_OV_FAULT    = 5;
	localparam int ST_STATE_LSB   = 8;
	localparam int ST_HS_ON_LSB   = 16;

	localparam logic [3:0] CTRL_RST       = 4'h0;
	localparam logic [7:0] PULSES_RST     = 8'h04;
	localparam logic [7:0] BURST_OFF_RST  = 8'h64;
	localparam logic [7:0] LOW_ON_RST     = 8'h05;
	localparam logic [7:0] HIGH_BASE_RST  = 8'h04;
	localparam logic [7:0] TZ_MIN_RST     = 8'h02;
	localparam logic [4:0] DEFICIT_RST    = 5'h00;

	// ----------------------------------------
	// pin inputs, each passes a two stage synchroniser
	// ----------------------------------------
	localparam int PIN_ABOVE_ON   = 0;
	localparam int PIN_BELOW_OFF  = 1;
	localparam int PIN_STRAP      = 2;
	localparam int PIN_DEMAG_LOW  = 3;
	localparam int PIN_BIAS_BAD   = 4;
	localparam int PIN_BIAS_OV    = 5;
	localparam int PIN_ZERO_CROSS = 6;
	localparam int PIN_ZVS_HIT    = 7;
	localparam int PIN_CS_TRIP    = 8;
	localparam int NPINS          = 9;

	typedef enum logic [3:0] {
		S_LOCKOUT,
		S_PATH_OPEN,
		S_IDLE,
		S_WAKE,
		S_ZC_WAIT,
		S_LOW_ON,
		S_DEAD_LH,
		S_HIGH_ON,
		S_DEAD_HL,
		S_FAULT
	} cfgt_state_t;

endpackage : cfgt_pkg

//--- core/cfgt_timing_if.sv
// timing set from strap sampler to sequencer
`timescale 1ns/10ps
interface cfgt_timing_if;
	logic       sample;
	logic       strap_high;
	logic [7:0] blank_cyc;
	logic [7:0] min_on_cyc;
	logic [7:0] csf_cyc;

	modport provider (input sample, output strap_high, output blank_cyc, output min_on_cyc, output csf_cyc);
	modport consumer (output sample, input strap_high, input blank_cyc, input min_on_cyc, input csf_cyc);
endinterface : cfgt_timing_if

//--- core/cfgt_timing_set.sv
// strap capture and per-strap timing selection
`timescale 1ns/10ps
module cfgt_timing_set
	import cfgt_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      strap_sync,
	input  wire logic      demag_low_sync,
	cfgt_timing_if.provider tif
);
	logic strap_q;
	logic strap_d;
	logic demag_q;
	logic demag_d;

	always_comb
	begin
		strap_d = strap_q;
		demag_d = demag_q;
		if (tif.sample)
		begin
			strap_d = strap_sync;
			demag_d = demag_low_sync;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			strap_q <= 1'b0;
			demag_q <= 1'b0;
		end
		else
		begin
			strap_q <= strap_d;
			demag_q <= demag_d;
		end
	end

	assign tif.strap_high = strap_q;
	assign tif.blank_cyc  = strap_q ? BLANK_REF_CYC : BLANK_GND_CYC;
	assign tif.min_on_cyc = strap_q ? MIN_ON_REF_CYC : MIN_ON_GND_CYC;
	assign tif.csf_cyc    = (strap_q || !demag_q) ? CSF_REF_CYC : CSF_GND_CYC;
endmodule : cfgt_timing_set

//--- core/cfgt_gate_timing.sv
// gate timing, power-path sequencing and registers
// Functional notes
// - open both startup switches at turn-on
// - then connect regulator to gate bias pin
// - zvs threshold 4 V grounded, 9 V strapped
// - bias pin fault at startup or overvoltage
// - programmable high-to-low transition wait
// - lengthen high-to-low wait at low bulk
// - tune high-side on-time each cycle except the last of a burst packet, which skips the high-to-low wait
// - driver enable high while driver operates
// - drop driver enable between burst packets
// - 2.2 us wake-up before first pulse
// - first pulse on zero cross or timeout
// - blank current sense 130/200 ns
// - minimum low-side on-time in low power
// - current sense fault on long on-time
// - lockout release and return thresholds
// - linear dead time extension up to 140%
// - high side 50 ns after zero cross, strapped only (code adds no ZC_TO_HIGH_CYC wait); grounded uses the fixed 40 ns low-to-high wait
`timescale 1ns/10ps
module cfgt_gate_timing
	import cfgt_pkg::*;
(
	input  wire logic                      CLK,
	input  wire logic                      RESETN,
	input  wire logic                      WB_CYC_I,
	input  wire logic                      WB_STB_I,
	input  wire logic                      WB_WE_I,
	input  wire logic [cfgt_pkg::WB_AW-1:0] WB_ADR_I,
	input  wire logic [3:0]                WB_SEL_I,
	input  wire logic [31:0]               WB_DAT_I,
	output logic      [31:0]               WB_DAT_O,
	output logic                           WB_ACK_O,
	input  wire logic                      SUPPLY_ABOVE_ON,
	input  wire logic                      SUPPLY_BELOW_OFF,
	input  wire logic                      STRAP_HIGH,
	input  wire logic                      DEMAG_RES_LOW,
	input  wire logic                      GATE_BIAS_BAD,
	input  wire logic                      GATE_BIAS_OVERVOLTAGE,
	input  wire logic                      AUX_ZERO_CROSS_DETECT,
	input  wire logic                      ZVS_THRESHOLD_REACHED,
	input  wire logic                      SENSE_TRIP,
	output logic                           STARTUP_SWITCH_NODE_CLOSE,
	output logic                           STARTUP_GATE_BIAS_CLOSE,
	output logic                           REGULATOR_CONNECT,
	output logic                           ZVS_TUNE_THRESHOLD_HIGH,
	output logic                           DRIVER_ENABLE,
	output logic                           LOW_SIDE_GATE_CMD,
	output logic                           HIGH_SIDE_GATE_CMD
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [NPINS-1:0] pins;
	logic [NPINS-1:0] meta_q;
	logic [NPINS-1:0] sync_q;

	assign pins = {SENSE_TRIP, ZVS_THRESHOLD_REACHED, AUX_ZERO_CROSS_DETECT, GATE_BIAS_OVERVOLTAGE,
		GATE_BIAS_BAD, DEMAG_RES_LOW, STRAP_HIGH, SUPPLY_BELOW_OFF, SUPPLY_ABOVE_ON};

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++)
		begin : g_sync
			always_ff @(posedge CLK)
			begin
				if (!RESETN)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi] <= pins[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// strap timing set
	// ----------------------------------------
	cfgt_timing_if tif ();

	cfgt_timing_set u_timing_set (
		.clk            (CLK),
		.rst_n          (RESETN),
		.strap_sync     (sync_q[PIN_STRAP]),
		.demag_low_sync (sync_q[PIN_DEMAG_LOW]),
		.tif            (tif.provider)
	);

	// ----------------------------------------
	// registers and bus slave
	// ----------------------------------------
	logic [3:0]  ctrl_q, ctrl_d;
	logic [7:0]  pulses_q, pulses_d;
	logic [7:0]  burst_off_q, burst_off_d;
	logic [7:0]  low_on_q, low_on_d;
	logic [7:0]  high_base_q, high_base_d;
	logic [7:0]  tz_min_q, tz_min_d;
	logic [4:0]  deficit_q, deficit_d;
	logic        cs_flag_q, cs_flag_d;
	logic        bias_flag_q, bias_flag_d;
	logic        ov_flag_q, ov_flag_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wr_en;
	logic [31:0] status;

	// sequencer signals used by the register group
	cfgt_state_t state_q, state_d;
	logic        released_q, released_d;
	logic [7:0]  hs_on_q, hs_on_d;
	logic        cs_event;
	logic        bias_event;
	logic        ov_event;

	assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;

	always_comb
	begin
		status = 32'h0;
		status[ST_RELEASED] = released_q;
		status[ST_STRAP] = tif.strap_high;
		status[ST_IN_FAULT] = (state_q == S_FAULT);
		status[ST_CS_FAULT] = cs_flag_q;
		status[ST_BIAS_FAULT] = bias_flag_q;
		status[ST_OV_FAULT] = ov_flag_q;
		status[ST_STATE_LSB +: 4] = state_q;
		status[ST_HS_ON_LSB +: 8] = hs_on_q;
	end

	always_comb
	begin
		ctrl_d = ctrl_q;
		pulses_d = pulses_q;
		burst_off_d = burst_off_q;
		low_on_d = low_on_q;
		high_base_d = high_base_q;
		tz_min_d = tz_min_q;
		deficit_d = deficit_q;
		cs_flag_d = cs_flag_q;
		bias_flag_d = bias_flag_q;
		ov_flag_d = ov_flag_q;
		ack_d = WB_CYC_I && WB_STB_I && !ack_q;
		rdata_d = 32'h0;
		if (wr_en && WB_SEL_I[0])
		begin
			if (WB_ADR_I == ADDR_CTRL)
				ctrl_d = WB_DAT_I[3:0];
			else if (WB_ADR_I == ADDR_PULSES)
				pulses_d = WB_DAT_I[7:0];
			else if (WB_ADR_I == ADDR_BURST_OFF)
				burst_off_d = WB_DAT_I[7:0];
			else if (WB_ADR_I == ADDR_LOW_ON)
				low_on_d = WB_DAT_I[7:0];
			else if (WB_ADR_I == ADDR_HIGH_BASE)
				high_base_d = WB_DAT_I[7:0];
			else if (WB_ADR_I == ADDR_TZ_MIN)
				tz_min_d = WB_DAT_I[7:0];
			else if (WB_ADR_I == ADDR_DEFICIT)
				deficit_d = (WB_DAT_I[4:0] > DEFICIT_MAX) ? DEFICIT_MAX : WB_DAT_I[4:0];
			else if (WB_ADR_I == ADDR_STATUS)
			begin
				cs_flag_d = cs_flag_q && !WB_DAT_I[ST_CS_FAULT];
				bias_flag_d = bias_flag_q && !WB_DAT_I[ST_BIAS_FAULT];
				ov_flag_d = ov_flag_q && !WB_DAT_I[ST_OV_FAULT];
			end
		end
		// hardware set wins over a same-cycle clear
		if (cs_event)
			cs_flag_d = 1'b1;
		if (bias_event)
			bias_flag_d = 1'b1;
		if (ov_event)
			ov_flag_d = 1'b1;
		if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q)
		begin
			if (WB_ADR_I == ADDR_CTRL)
				rdata_d = {28'h0, ctrl_q};
			else if (WB_ADR_I == ADDR_PULSES)
				rdata_d = {24'h0, pulses_q};
			else if (WB_ADR_I == ADDR_BURST_OFF)
				rdata_d = {24'h0, burst_off_q};
			else if (WB_ADR_I == ADDR_LOW_ON)
				rdata_d = {24'h0, low_on_q};
			else if (WB_ADR_I == ADDR_HIGH_BASE)
				rdata_d = {24'h0, high_base_q};
			else if (WB_ADR_I == ADDR_TZ_MIN)
				rdata_d = {24'h0, tz_min_q};
			else if (WB_ADR_I == ADDR_DEFICIT)
				rdata_d = {27'h0, deficit_q};
			else if (WB_ADR_I == ADDR_STATUS)
				rdata_d = status;
			else
				rdata_d = 32'h0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			ctrl_q <= CTRL_RST;
			pulses_q <= PULSES_RST;
			burst_off_q <= BURST_OFF_RST;
			low_on_q <= LOW_ON_RST;
			high_base_q <= HIGH_BASE_RST;
			tz_min_q <= TZ_MIN_RST;
			deficit_q <= DEFICIT_RST;
			cs_flag_q <= 1'b0;
			bias_flag_q <= 1'b0;
			ov_flag_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			pulses_q <= pulses_d;
			burst_off_q <= burst_off_d;
			low_on_q <= low_on_d;
			high_base_q <= high_base_d;
			tz_min_q <= tz_min_d;
			deficit_q <= deficit_d;
			cs_flag_q <= cs_flag_d;
			bias_flag_q <= bias_flag_d;
			ov_flag_q <= ov_flag_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;

	// ----------------------------------------
	// gate sequencer
	// ----------------------------------------
	logic [7:0]  cnt_q, cnt_d;
	logic [7:0]  left_q, left_d;
	logic        bias_bad_q, bias_bad_d;
	logic        path_sws_q, path_sws_d;
	logic        path_gate_q, path_gate_d;
	logic        reg_conn_q, reg_conn_d;
	logic        drv_en_q, drv_en_d;
	logic        low_q, low_d;
	logic        high_q, high_d;
	logic        zvs_high_q, zvs_high_d;
	logic [12:0] ext_prod;
	logic [8:0]  tz_sum;
	logic [7:0]  tz_cyc;
	logic        no_high;
	logic        burst;
	logic        low_end;
	logic        zc;

	assign ext_prod = tz_min_q * deficit_q;
	assign tz_sum   = {1'b0, tz_min_q} + 9'(ext_prod / EXT_DIVISOR);
	assign tz_cyc   = tz_sum[8] ? 8'hff : tz_sum[7:0];
	assign no_high  = ctrl_q[CTRL_LOW_POWER] || ctrl_q[CTRL_STANDBY];
	assign burst    = ctrl_q[CTRL_BURST] || no_high;
	assign zc       = sync_q[PIN_ZERO_CROSS];
	assign tif.sample = (state_q == S_LOCKOUT) && released_q;
	assign low_end  = ((sync_q[PIN_CS_TRIP] && cnt_q >= tif.blank_cyc) || cnt_q + 8'h01 >= low_on_q)
		&& (!no_high || cnt_q + 8'h01 >= tif.min_on_cyc);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q + 8'h01;
		left_d = left_q;
		hs_on_d = hs_on_q;
		bias_bad_d = bias_bad_q;
		cs_event = 1'b0;
		bias_event = 1'b0;
		ov_event = 1'b0;
		released_d = released_q ? !sync_q[PIN_BELOW_OFF] : sync_q[PIN_ABOVE_ON];
		if (!ctrl_q[CTRL_RUN])
			hs_on_d = high_base_q;
		case (state_q)
			S_LOCKOUT:
			begin
				// bias pin open or shorted during startup
				bias_bad_d = bias_bad_q || sync_q[PIN_BIAS_BAD];
				if (released_q)
					state_d = S_PATH_OPEN;
			end
			S_PATH_OPEN:
			begin
				if (bias_bad_q)
				begin
					bias_event = 1'b1;
					state_d = S_FAULT;
				end
				else
					state_d = S_IDLE;
			end
			S_IDLE:
			begin
				if (ctrl_q[CTRL_RUN] && cnt_q >= burst_off_q)
				begin
					state_d = S_WAKE;
					cnt_d = 8'h0;
					left_d = pulses_q;
				end
			end
			S_WAKE:
			begin
				if (cnt_q + 8'h01 >= WAKE_CYC)
				begin
					state_d = S_ZC_WAIT;
					cnt_d = 8'h0;
				end
			end
			S_ZC_WAIT:
			begin
				if (zc || cnt_q + 8'h01 >= ZC_TIMEOUT_CYC)
				begin
					state_d = S_LOW_ON;
					cnt_d = 8'h0;
				end
			end
			S_LOW_ON:
			begin
				if (cnt_q + 8'h01 >= tif.csf_cyc && !low_end)
				begin
					cs_event = 1'b1;
					state_d = S_FAULT;
				end
				else if (low_end)
				begin
					cnt_d = 8'h0;
					left_d = left_q - 8'h01;
					if (!no_high)
						state_d = S_DEAD_LH;
					else if (burst && left_q <= 8'h01)
						state_d = S_IDLE;
					else
						state_d = S_ZC_WAIT;
				end
			end
			S_DEAD_LH:
			begin
				if (!tif.strap_high && cnt_q + 8'h01 >= LH_FIXED_CYC)
				begin
					state_d = S_HIGH_ON;
					cnt_d = 8'h0;
				end
				else if (tif.strap_high && (zc || cnt_q + 8'h01 >= ZC_TIMEOUT_CYC))
				begin
					state_d = S_HIGH_ON;
					cnt_d = 8'h0;
				end
			end
			S_HIGH_ON:
			begin
				if (cnt_q + 8'h01 >= hs_on_q)
				begin
					cnt_d = 8'h0;
					state_d = (burst && left_q == 8'h0) ? S_IDLE : S_DEAD_HL;
				end
			end
			S_DEAD_HL:
			begin
				// wait for the switch node to fall
				if (cnt_q + 8'h01 >= tz_cyc)
				begin
					state_d = S_LOW_ON;
					cnt_d = 8'h0;
					// lengthen on-time on a miss, trim on a hit
					if (!sync_q[PIN_ZVS_HIT] && hs_on_q != 8'hff)
						hs_on_d = hs_on_q + 8'h01;
					else if (sync_q[PIN_ZVS_HIT] && hs_on_q > 8'h01)
						hs_on_d = hs_on_q - 8'h01;
				end
			end
			S_FAULT:
			begin
				cnt_d = 8'h0;
			end
			default:
			begin
				state_d = S_LOCKOUT;
			end
		endcase
		if (state_q != S_LOCKOUT && state_q != S_PATH_OPEN && state_q != S_FAULT && sync_q[PIN_BIAS_OV])
		begin
			ov_event = 1'b1;
			state_d = S_FAULT;
		end
		// run off ends the packet at once
		if (!ctrl_q[CTRL_RUN] && state_q != S_FAULT && state_q != S_LOCKOUT && state_q != S_PATH_OPEN)
			state_d = S_IDLE;
		if (state_d == S_IDLE && state_q != S_IDLE)
			cnt_d = 8'h0;
		else if (state_q == S_IDLE && cnt_q == 8'hff)
			cnt_d = cnt_q;
		if (!released_q)
		begin
			state_d = S_LOCKOUT;
			cnt_d = 8'h0;
		end
		if (state_q != S_LOCKOUT)
			bias_bad_d = 1'b0;
		// startup switches closed only in lockout
		path_sws_d = (state_d == S_LOCKOUT);
		path_gate_d = (state_d == S_LOCKOUT);
		// regulator joins one cycle after the switches open
		reg_conn_d = (state_d != S_LOCKOUT) && (state_d != S_PATH_OPEN);
		zvs_high_d = tif.strap_high;
		// driver enable and both gate commands low in lockout or fault
		drv_en_d = (state_d == S_WAKE) || (state_d == S_ZC_WAIT) || (state_d == S_LOW_ON)
			|| (state_d == S_DEAD_LH) || (state_d == S_HIGH_ON) || (state_d == S_DEAD_HL)
			|| (state_d == S_IDLE && !burst && ctrl_q[CTRL_RUN] && state_q != S_PATH_OPEN);
		low_d = (state_d == S_LOW_ON);
		high_d = (state_d == S_HIGH_ON);
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			state_q <= S_LOCKOUT;
			released_q <= 1'b0;
			cnt_q <= 8'h0;
			left_q <= 8'h0;
			hs_on_q <= HIGH_BASE_RST;
			bias_bad_q <= 1'b0;
			path_sws_q <= 1'b1;
			path_gate_q <= 1'b1;
			reg_conn_q <= 1'b0;
			zvs_high_q <= 1'b0;
			drv_en_q <= 1'b0;
			low_q <= 1'b0;
			high_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			released_q <= released_d;
			cnt_q <= cnt_d;
			left_q <= left_d;
			hs_on_q <= hs_on_d;
			bias_bad_q <= bias_bad_d;
			path_sws_q <= path_sws_d;
			path_gate_q <= path_gate_d;
			reg_conn_q <= reg_conn_d;
			zvs_high_q <= zvs_high_d;
			drv_en_q <= drv_en_d;
			low_q <= low_d;
			high_q <= high_d;
		end
	end

	assign STARTUP_SWITCH_NODE_CLOSE = path_sws_q;
	assign STARTUP_GATE_BIAS_CLOSE   = path_gate_q;
	assign REGULATOR_CONNECT         = reg_conn_q;
	assign ZVS_TUNE_THRESHOLD_HIGH   = zvs_high_q;
	assign DRIVER_ENABLE             = drv_en_q;
	assign LOW_SIDE_GATE_CMD         = low_q;
	assign HIGH_SIDE_GATE_CMD        = high_q;
endmodule : cfgt_gate_timing

//--- verif/cfgt_props.sv
// gate timing assertions
`timescale 1ns/10ps
module cfgt_props
	import cfgt_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic STARTUP_SWITCH_NODE_CLOSE,
	input wire logic STARTUP_GATE_BIAS_CLOSE,
	input wire logic REGULATOR_CONNECT,
	input wire logic ZVS_TUNE_THRESHOLD_HIGH,
	input wire logic DRIVER_ENABLE,
	input wire logic LOW_SIDE_GATE_CMD,
	input wire logic HIGH_SIDE_GATE_CMD
);
	logic [7:0] en_q, en_d, lo_q, lo_d, rel_q, rel_d;

	// saturating run lengths, so long runs never wrap
	always_comb
	begin
		en_d = !DRIVER_ENABLE ? 8'h00 : en_q + 8'(en_q != 8'hff);
		lo_d = !LOW_SIDE_GATE_CMD ? 8'h00 : lo_q + 8'(lo_q != 8'hff);
		rel_d = STARTUP_SWITCH_NODE_CLOSE ? 8'h00 : rel_q + 8'(rel_q != 8'hff);
	end
	always_ff @(posedge CLK)
	begin
		en_q <= RESETN ? en_d : 8'h00;
		lo_q <= RESETN ? lo_d : 8'h00;
		rel_q <= RESETN ? rel_d : 8'h00;
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_SWITCH_PAIR: assert property (STARTUP_SWITCH_NODE_CLOSE == STARTUP_GATE_BIAS_CLOSE)
		else $error("startup switches differ");
	AST_REG_AFTER_OPEN: assert property ($rose(REGULATOR_CONNECT) |->
		$past(!STARTUP_SWITCH_NODE_CLOSE) && !STARTUP_GATE_BIAS_CLOSE)
		else $error("regulator before open");
	AST_THRESH_HOLD: assert property (!STARTUP_SWITCH_NODE_CLOSE && rel_q > 8'h04 |->
		$stable(ZVS_TUNE_THRESHOLD_HIGH))
		else $error("threshold moved");
	AST_LOCKOUT_QUIET: assert property (STARTUP_SWITCH_NODE_CLOSE |->
		!DRIVER_ENABLE && !LOW_SIDE_GATE_CMD && !HIGH_SIDE_GATE_CMD)
		else $error("drive active in lockout");
	AST_GATES_NEED_EN: assert property (LOW_SIDE_GATE_CMD || HIGH_SIDE_GATE_CMD |-> DRIVER_ENABLE)
		else $error("gate without enable");
	AST_WAKE_FIRST: assert property ($rose(LOW_SIDE_GATE_CMD) |-> en_q >= WAKE_CYC)
		else $error("pulse inside wake");
	AST_WAKE_BOUND: assert property ($rose(DRIVER_ENABLE) |-> ##[22:48] $rose(LOW_SIDE_GATE_CMD))
		else $error("first pulse late");
	AST_BLANK_MIN: assert property ($rose(LOW_SIDE_GATE_CMD) |-> LOW_SIDE_GATE_CMD[*2])
		else $error("pulse under blanking");
	AST_CSF_LIMIT: assert property (lo_q <= CSF_REF_CYC)
		else $error("on beyond limit");
	AST_DEAD_HL: assert property ($fell(HIGH_SIDE_GATE_CMD) |-> !LOW_SIDE_GATE_CMD[*2])
		else $error("wait too short");
	AST_DEAD_LH: assert property ($fell(LOW_SIDE_GATE_CMD) |-> !HIGH_SIDE_GATE_CMD)
		else $error("no low-high dead time");
endmodule : cfgt_props

bind cfgt_gate_timing cfgt_props u_props (
	.CLK(CLK), .RESETN(RESETN), .STARTUP_SWITCH_NODE_CLOSE(STARTUP_SWITCH_NODE_CLOSE),
	.STARTUP_GATE_BIAS_CLOSE(STARTUP_GATE_BIAS_CLOSE), .REGULATOR_CONNECT(REGULATOR_CONNECT),
	.ZVS_TUNE_THRESHOLD_HIGH(ZVS_TUNE_THRESHOLD_HIGH), .DRIVER_ENABLE(DRIVER_ENABLE),
	.LOW_SIDE_GATE_CMD(LOW_SIDE_GATE_CMD), .HIGH_SIDE_GATE_CMD(HIGH_SIDE_GATE_CMD)
);

//--- verif/cfgt_driver_model.sv
// behavioural half-bridge driver and power stage
`timescale 1ns/10ps
module cfgt_driver_model
(
	input  wire logic       clk,
	input  wire logic       drv_en,
	input  wire logic       low_cmd,
	input  wire logic       high_cmd,
	input  wire logic       zc_on,
	input  wire logic [7:0] trip_cyc,
	input  wire logic [7:0] hs_need,
	output logic            zero_cross,
	output logic            zvs_hit,
	output logic            sense_trip
);
	logic [7:0] on_n, hs_n;
	logic [1:0] ring;

	initial
	begin
		{on_n, hs_n, ring, zero_cross, zvs_hit, sense_trip} = '0;
	end

	always @(posedge clk)
	begin
		// ramps only while awake; trip_cyc 0 means never
		on_n <= (low_cmd && drv_en) ? on_n + 8'h01 : 8'h00;
		sense_trip <= low_cmd && drv_en && trip_cyc != 8'h00 && on_n + 8'h01 >= trip_cyc;
		ring <= ring + 2'h1;
		// ringing only with both switches off
		zero_cross <= zc_on && !low_cmd && !high_cmd && ring == 2'h3;
		hs_n <= high_cmd ? hs_n + 8'h01 : 8'h00;
		if (high_cmd)
			zvs_hit <= 1'b0;
		else if (hs_n != 8'h00)
			zvs_hit <= hs_n >= hs_need;
	end
endmodule : cfgt_driver_model

//--- verif/clamp_flyback_gate_timing_tb_top.sv
// bench for the gate timing block
`timescale 1ns/10ps
module clamp_flyback_gate_timing_tb_top;
	import cfgt_pkg::*;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} cfgt_row_t;
	logic clk, rst_n, cyc, stb, we, ack, above, below, strap, dlow, bbad, bov, zc, zvs, trip, p;
	logic sw_sn, sw_gb, regc, zth, de, lo, hi, zc_on;
	logic [7:0] adr, trip_cyc, hs_need;
	logic [31:0] wdat, rdat, r;
	int errors, n_checks, n, k, c, j;
	cfgt_row_t rows [11] = '{'{ADDR_CTRL, 1'b0, 32'h0, 32'(CTRL_RST)},
		'{ADDR_PULSES, 1'b0, 32'h0, 32'(PULSES_RST)}, '{ADDR_BURST_OFF, 1'b0, 32'h0, 32'(BURST_OFF_RST)},
		'{ADDR_LOW_ON, 1'b0, 32'h0, 32'(LOW_ON_RST)}, '{ADDR_HIGH_BASE, 1'b0, 32'h0, 32'(HIGH_BASE_RST)},
		'{ADDR_TZ_MIN, 1'b0, 32'h0, 32'(TZ_MIN_RST)}, '{ADDR_DEFICIT, 1'b0, 32'h0, 32'(DEFICIT_RST)},
		'{ADDR_DEFICIT, 1'b1, 32'h1f, 32'h0}, '{ADDR_DEFICIT, 1'b0, 32'h0, 32'h10},
		'{8'h40, 1'b1, 32'h5a, 32'h0}, '{8'h40, 1'b0, 32'h0, 32'h0}};

	cfgt_gate_timing u_dut (.CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.SUPPLY_ABOVE_ON(above), .SUPPLY_BELOW_OFF(below), .STRAP_HIGH(strap), .DEMAG_RES_LOW(dlow),
		.GATE_BIAS_BAD(bbad), .GATE_BIAS_OVERVOLTAGE(bov), .AUX_ZERO_CROSS_DETECT(zc),
		.ZVS_THRESHOLD_REACHED(zvs), .SENSE_TRIP(trip), .STARTUP_SWITCH_NODE_CLOSE(sw_sn),
		.STARTUP_GATE_BIAS_CLOSE(sw_gb), .REGULATOR_CONNECT(regc), .ZVS_TUNE_THRESHOLD_HIGH(zth),
		.DRIVER_ENABLE(de), .LOW_SIDE_GATE_CMD(lo), .HIGH_SIDE_GATE_CMD(hi));
	cfgt_driver_model u_drv (.clk(clk), .drv_en(de), .low_cmd(lo), .high_cmd(hi), .zc_on(zc_on),
		.trip_cyc(trip_cyc), .hs_need(hs_need), .zero_cross(zc), .zvs_hit(zvs), .sense_trip(trip));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// caller stands just after a rising edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (ack !== 1'b1 && i < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			chk("bus ack", 32'(ack), 32'h1);
			complete_run();
		end
		@(posedge clk);
	endtask : wb

	function logic sig(input int s);
		case (s)
			0: sig = sw_sn;
			1: sig = de;
			2: sig = lo;
			default: sig = hi;
		endcase
	endfunction : sig

	task wt(input int s, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (sig(s) !== v && cnt < lim)
		begin
			@(posedge clk);
			cnt++;
		end
		if (sig(s) !== v)
		begin
			chk("wait", 32'(s), 32'hff);
			complete_run();
		end
	endtask : wt

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		{errors, n_checks} = '0;
		{rst_n, cyc, stb, we, above, strap, dlow, bbad, bov, zc_on} = '0;
		below = 1'b1;
		{adr, wdat} = '0;
		trip_cyc = 8'h03;
		hs_need = 8'hc8;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("lockout outputs", 32'({sw_sn, sw_gb, regc, de, lo, hi}), 32'h30);
		foreach (rows[i])
		begin
			wb(rows[i].w, rows[i].a, rows[i].d, r);
			if (!rows[i].w)
				chk("register read", r, rows[i].e);
		end
		$display("regs done");
		wb(1'b1, ADDR_PULSES, 32'h2, r);
		wb(1'b1, ADDR_BURST_OFF, 32'h10, r);
		below <= 1'b0;
		above <= 1'b1;
		wt(0, 1'b0, 30, n);
		chk("reg at open", 32'(regc), 32'h0);
		@(posedge clk);
		chk("reg after open", 32'(regc), 32'h1);
		chk("thr grounded", 32'(zth), 32'h0);
		$display("release done");
		wb(1'b1, ADDR_CTRL, 32'h3, r);
		for (k = 0; k < 2; k++)
		begin
			zc_on <= k[0];
			wt(1, 1'b1, 300, n);
			wt(2, 1'b1, 100, n);
			if (k == 0)
				chk("timeout delay", 32'(n), 32'(WAKE_CYC + ZC_TIMEOUT_CYC));
			else
				chk("zero cross delay", 32'(n >= WAKE_CYC && n <= WAKE_CYC + 8), 32'h1);
			c = 1;
			p = 1'b1;
			for (j = 0; j < 400 && de === 1'b1; j++)
			begin
				@(posedge clk);
				c += int'(lo === 1'b1 && p !== 1'b1);
				p = lo;
			end
			chk("pulses per packet", 32'(c), 32'h2);
			chk("enable off", 32'(de), 32'h0);
		end
		wb(1'b0, ADDR_STATUS, 32'h0, r);
		chk("on-time grew", 32'(r[23:16] > HIGH_BASE_RST), 32'h1);
		$display("burst done");
		bov <= 1'b1;
		repeat (8) @(posedge clk);
		wb(1'b0, ADDR_STATUS, 32'h0, r);
		chk("overvoltage fault", 32'(r[5:2]), 32'h9);
		repeat (60) @(posedge clk);
		chk("fault outputs", 32'({de, lo, hi}), 32'h0);
		{bov, above, below} <= 3'b001;
		wt(0, 1'b1, 30, n);
		chk("lockout return", 32'({sw_gb, regc}), 32'h2);
		bbad <= 1'b1;
		repeat (4) @(posedge clk);
		{above, below} <= 2'b10;
		repeat (40) @(posedge clk);
		wb(1'b0, ADDR_STATUS, 32'h0, r);
		chk("bias fault", 32'({r[4], r[2], de}), 32'h6);
		{bbad, above, below} <= 3'b001;
		wt(0, 1'b1, 30, n);
		wb(1'b1, ADDR_STATUS, 32'h38, r);
		$display("faults done");
		strap <= 1'b1;
		repeat (4) @(posedge clk);
		{above, below} <= 2'b10;
		wt(0, 1'b0, 30, n);
		repeat (4) @(posedge clk);
		chk("thr strapped", 32'(zth), 32'h1);
		strap <= 1'b0;
		repeat (10) @(posedge clk);
		chk("thr held", 32'(zth), 32'h1);
		wb(1'b1, ADDR_TZ_MIN, 32'h0a, r);
		wb(1'b1, ADDR_LOW_ON, 32'h30, r);
		wb(1'b1, ADDR_CTRL, 32'h1, r);
		for (k = 0; k < 2; k++)
		begin
			wb(1'b1, ADDR_DEFICIT, 32'(k * 16), r);
			wt(3, 1'b0, 300, n);
			wt(3, 1'b1, 300, n);
			wt(3, 1'b0, 300, n);
			wt(2, 1'b1, 50, n);
			chk("transition wait", 32'(n), 32'(10 + k * 4));
		end
		wt(2, 1'b0, 100, n);
		trip_cyc <= 8'h00;
		wt(2, 1'b1, 100, n);
		wt(2, 1'b0, 100, n);
		chk("on-time limit", 32'(n), 32'(CSF_REF_CYC));
		wb(1'b0, ADDR_STATUS, 32'h0, r);
		chk("sense fault flag", 32'(r[3]), 32'h1);
		$display("strap done");
		complete_run();
	end
endmodule : clamp_flyback_gate_timing_tb_top
